// ==== core/dcff_pkg.sv ====
// Purpose: Shared constants and types for the FIFO read/flag controller
// Assumes: APB with 32-bit data, each register on an aligned word
// Notes:   Offset table values are plain defaults and may be retuned
package dcff_pkg;

  localparam int DCFF_DEPTH_DEF = 1024;
  localparam int DCFF_WIDTH_DEF = 32;
  localparam int DCFF_PADDR_W   = 12;
  localparam int DCFF_SYNC_W    = 13;

  // Register byte addresses
  localparam logic [11:0] DCFF_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] DCFF_STATUS_ADDR = 12'h004;
  localparam logic [11:0] DCFF_LEVEL_ADDR  = 12'h008;
  localparam logic [11:0] DCFF_OFFSET_ADDR = 12'h00C;

  // Field positions
  localparam int DCFF_CTRL_FREEZE_BIT = 0;
  localparam int DCFF_ST_FLAGS_LSB    = 0;
  localparam int DCFF_ST_SERIAL_BIT   = 5;
  localparam int DCFF_ST_MODE_BIT     = 6;
  localparam int DCFF_OFS_FULL_LSB    = 16;

  // Values after reset
  localparam logic        DCFF_FREEZE_RST = 1'b0;
  localparam logic [15:0] DCFF_OFS_RST    = 16'h0000;

  // Default offset pairs picked by {load, select1, select0} at master reset
  localparam logic [15:0] DCFF_DEF_OFS [8] = '{
    16'h0007, 16'h000F, 16'h001F, 16'h003F,
    16'h007F, 16'h00FF, 16'h01FF, 16'h03FF
  };

  typedef struct packed {
    logic fullN;
    logic emptyN;
    logic almostFullN;
    logic almostEmptyN;
    logic halfFullN;
  } dcff_flags_t;

  localparam dcff_flags_t DCFF_FLAGS_RST = '{
    fullN:        1'b1,
    emptyN:       1'b0,
    almostFullN:  1'b1,
    almostEmptyN: 1'b0,
    halfFullN:    1'b1
  };

endpackage

// ==== core/dcff_ctrl.sv ====
// Purpose: Read port, output register and status flags of a FIFO whose
//          write and read clocks arrive as pins, plus offset programming
// Assumes: Pin clocks run well below clk_sys/4 so every edge is seen
// Notes:   All pin inputs pass a two-stage synchroniser; the pin clocks
//          become one-cycle edge strobes inside the clk_sys domain
//
// Notes on behaviour
// - Read enable low and data present: next word enters output register.
// - Read enable high: output register and outputs hold their value.
// - Every word, even the first, needs its own read request.
// - Empty flag low after last read; reads ignored until a write.
// - Empty flag sees a write two read edges after it.
// - Serial enable and load both low shift one offset bit per write edge.
// - Serial enable high keeps offsets, no bits shifted.
// - Output enable low drives the data outputs, high floats them.
// - Master reset samples load and two selects: default pair or serial.
// - After reset, serial loading starts with load and serial enable low.
// - Flag timing mode latched at master reset: low async, high sync.
// - Sync mode: almost-empty on read edges, almost-full on write edges.
// - Async mode: almost-full set on write edge, cleared on read edge.
// - Async mode: almost-empty set on read edge, cleared on write edge.
// - Full flag low when all locations hold data, blocking writes.
// - Full flag changes only on write edges, two registered stages.
// - Empty flag changes only on read edges, two registered stages.
// - Almost-full low once stored words reach depth minus full offset.
// - Almost-empty low while stored words are at or below empty offset.
// - Half-full low on write above half depth, high on read back.
// - Data word is 16 or 32 bits wide.
// - Either reset: pointers home, output cleared, flags to reset levels.
// - Serial bits go empty offset LSB first to full offset MSB last.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

module dcff_ctrl #(
  parameter int DEPTH = dcff_pkg::DCFF_DEPTH_DEF,
  parameter int WIDTH = dcff_pkg::DCFF_WIDTH_DEF
) (
  input  wire logic                             clk_sys,
  input  wire logic                             nrst,
  input  wire logic                             clkEn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [dcff_pkg::DCFF_PADDR_W-1:0] paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             writeClkPin,
  input  wire logic                             readClkPin,
  input  wire logic                             writeEnN,
  input  wire logic                             readEnN,
  input  wire logic                             outputEnN,
  input  wire logic                             serialEnableN,
  input  wire logic                             offsetLoadN,
  input  wire logic                             serialIn,
  input  wire logic                             offsetSelect0,
  input  wire logic                             offsetSelect1,
  input  wire logic                             flagTimingMode,
  input  wire logic                             masterResetN,
  input  wire logic                             partialResetN,
  input  wire logic [WIDTH-1:0]                 writeDataIn,
  output logic      [WIDTH-1:0]                 readDataOut,
  output logic                                  readDataOe,
  output dcff_pkg::dcff_flags_t                 flags
);
  import dcff_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int SW = DCFF_SYNC_W + WIDTH;
  localparam logic [AW:0] DEPTH_L = (AW+1)'(DEPTH);
  localparam logic [AW:0] HALF_L  = (AW+1)'(DEPTH / 2);

  // Synchroniser: first stage read only by the second
  logic [SW-1:0]    pinRaw;
  logic [SW-1:0]    pinMeta_reg;
  logic [SW-1:0]    pinSync_reg;
  logic             wClkPrev_reg;
  logic             rClkPrev_reg;

  assign pinRaw = {writeDataIn, writeClkPin, readClkPin, writeEnN, readEnN,
                   outputEnN, serialEnableN, offsetLoadN, serialIn,
                   offsetSelect0, offsetSelect1, flagTimingMode,
                   masterResetN, partialResetN};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
    end else if (clkEn) begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
    end
  end

  logic [WIDTH-1:0] dataInS;
  logic             wClkS;
  logic             rClkS;
  logic             wEnNS;
  logic             rEnNS;
  logic             oeNS;
  logic             serEnNS;
  logic             loadNS;
  logic             serInS;
  logic             sel0S;
  logic             sel1S;
  logic             modeS;
  logic             mrNS;
  logic             prNS;

  assign {dataInS, wClkS, rClkS, wEnNS, rEnNS, oeNS, serEnNS, loadNS, serInS,
          sel0S, sel1S, modeS, mrNS, prNS} = pinSync_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wClkPrev_reg <= 1'b0;
      rClkPrev_reg <= 1'b0;
    end else if (clkEn) begin
      wClkPrev_reg <= wClkS;
      rClkPrev_reg <= rClkS;
    end
  end

  logic wEdge;
  logic rEdge;
  logic resetAny;
  assign wEdge    = wClkS & ~wClkPrev_reg;
  assign rEdge    = rClkS & ~rClkPrev_reg;
  assign resetAny = ~mrNS | ~prNS;

  // State
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wPtr_reg;
  logic [AW:0]      rPtr_reg;
  logic [AW:0]      wPtrRd_reg;
  logic [AW:0]      rPtrWr_reg;
  logic [WIDTH-1:0] dataOut_reg;
  dcff_flags_t      flags_reg;
  logic [AW-1:0]    emptyOfs_reg;
  logic [AW-1:0]    fullOfs_reg;
  logic             serialOk_reg;
  logic             asyncMode_reg;
  logic             freeze_reg;

  logic             doWrite;
  logic             doRead;
  logic             doShift;
  logic             apbWrite;
  logic [AW:0]      wPtrNew;
  logic [AW:0]      rPtrNew;
  logic [AW:0]      levelNew;
  logic [AW:0]      levelWrView;
  logic [AW:0]      levelRdView;
  logic [AW:0]      afThresh;
  logic [WIDTH-1:0] headWord;

  // Writes need load high; a low load belongs to offset programming
  assign doWrite = wEdge & ~wEnNS & loadNS & flags_reg.fullN & ~resetAny;
  assign doRead  = rEdge & ~rEnNS & flags_reg.emptyN & ~freeze_reg
                   & ~resetAny;
  assign doShift = wEdge & ~serEnNS & ~loadNS & serialOk_reg
                   & ~resetAny;
  assign apbWrite = psel & penable & pwrite & (paddr == DCFF_OFFSET_ADDR);

  assign wPtrNew     = wPtr_reg + (AW+1)'(doWrite);
  assign rPtrNew     = rPtr_reg + (AW+1)'(doRead);
  assign levelNew    = wPtrNew - rPtrNew;
  assign levelWrView = wPtrNew - rPtrWr_reg;
  assign levelRdView = wPtrRd_reg - rPtrNew;
  assign afThresh    = DEPTH_L - {1'b0, fullOfs_reg};
  assign headWord    = mem_reg[rPtr_reg[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (clkEn && doWrite) begin
      mem_reg[wPtr_reg[AW-1:0]] <= dataInS;
    end
  end

  // Pointers and their copies seen by the opposite side
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wPtr_reg   <= '0;
      rPtr_reg   <= '0;
      wPtrRd_reg <= '0;
      rPtrWr_reg <= '0;
    end else if (clkEn) begin
      if (resetAny) begin
        wPtr_reg   <= '0;
        rPtr_reg   <= '0;
        wPtrRd_reg <= '0;
        rPtrWr_reg <= '0;
      end else begin
        wPtr_reg <= wPtrNew;
        rPtr_reg <= rPtrNew;
        if (rEdge) begin
          wPtrRd_reg <= wPtr_reg;
        end
        if (wEdge) begin
          rPtrWr_reg <= rPtr_reg;
        end
      end
    end
  end

  // Output register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dataOut_reg <= '0;
    end else if (clkEn) begin
      if (resetAny) begin
        dataOut_reg <= '0;
      end else if (doRead) begin
        dataOut_reg <= headWord;
      end
    end
  end

  assign readDataOut = dataOut_reg;
  assign readDataOe  = ~oeNS;

  // Full and empty: stale copy of the far pointer plus the flag register
  // gives two stages; the stale copy only ever errs on the safe side
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_reg.fullN  <= DCFF_FLAGS_RST.fullN;
      flags_reg.emptyN <= DCFF_FLAGS_RST.emptyN;
    end else if (clkEn) begin
      if (resetAny) begin
        flags_reg.fullN  <= DCFF_FLAGS_RST.fullN;
        flags_reg.emptyN <= DCFF_FLAGS_RST.emptyN;
      end else begin
        if (wEdge) begin
          flags_reg.fullN <= (levelWrView < DEPTH_L);
        end
        if (rEdge) begin
          flags_reg.emptyN <= (levelRdView != '0);
        end
      end
    end
  end

  // Almost-full
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_reg.almostFullN <= DCFF_FLAGS_RST.almostFullN;
    end else if (clkEn) begin
      if (resetAny) begin
        flags_reg.almostFullN <= DCFF_FLAGS_RST.almostFullN;
      end else if (!asyncMode_reg) begin
        if (wEdge) begin
          flags_reg.almostFullN <= (levelWrView < afThresh);
        end
      end else if (wEdge && levelNew >= afThresh) begin
        flags_reg.almostFullN <= 1'b0;
      end else if (rEdge && levelNew < afThresh) begin
        flags_reg.almostFullN <= 1'b1;
      end
    end
  end

  // Almost-empty
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_reg.almostEmptyN <= DCFF_FLAGS_RST.almostEmptyN;
    end else if (clkEn) begin
      if (resetAny) begin
        flags_reg.almostEmptyN <= DCFF_FLAGS_RST.almostEmptyN;
      end else if (!asyncMode_reg) begin
        if (rEdge) begin
          flags_reg.almostEmptyN <=
            (levelRdView > {1'b0, emptyOfs_reg});
        end
      end else if (rEdge && levelNew <= {1'b0, emptyOfs_reg}) begin
        flags_reg.almostEmptyN <= 1'b0;
      end else if (wEdge && levelNew > {1'b0, emptyOfs_reg}) begin
        flags_reg.almostEmptyN <= 1'b1;
      end
    end
  end

  // Half-full: write side only sets it, read side only clears it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flags_reg.halfFullN <= DCFF_FLAGS_RST.halfFullN;
    end else if (clkEn) begin
      if (resetAny) begin
        flags_reg.halfFullN <= DCFF_FLAGS_RST.halfFullN;
      end else if (doWrite && levelNew > HALF_L) begin
        flags_reg.halfFullN <= 1'b0;
      end else if (doRead && levelNew <= HALF_L) begin
        flags_reg.halfFullN <= 1'b1;
      end
    end
  end

  assign flags = flags_reg;

  // Straps and offsets; partial reset keeps them
  logic [2:0] strapIdx;
  assign strapIdx = {loadNS, sel1S, sel0S};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      emptyOfs_reg  <= DCFF_OFS_RST[AW-1:0];
      fullOfs_reg   <= DCFF_OFS_RST[AW-1:0];
      serialOk_reg  <= 1'b0;
      asyncMode_reg <= 1'b0;
    end else if (clkEn) begin
      if (!mrNS) begin
        emptyOfs_reg  <= DCFF_DEF_OFS[strapIdx][AW-1:0];
        fullOfs_reg   <= DCFF_DEF_OFS[strapIdx][AW-1:0];
        serialOk_reg  <= loadNS;
        asyncMode_reg <= ~modeS;
      end else if (apbWrite) begin
        emptyOfs_reg <= pwdata[AW-1:0];
        fullOfs_reg  <= pwdata[DCFF_OFS_FULL_LSB +: AW];
      end else if (doShift) begin
        // New bit enters at the top so the first ends at empty LSB
        {fullOfs_reg, emptyOfs_reg} <=
          {serInS, fullOfs_reg, emptyOfs_reg[AW-1:1]};
      end
    end
  end

  // APB slave, zero wait states
  logic ctrlSel;
  assign ctrlSel = psel & penable & pwrite & (paddr == DCFF_CTRL_ADDR);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      freeze_reg <= DCFF_FREEZE_RST;
    end else if (clkEn && ctrlSel) begin
      freeze_reg <= pwdata[DCFF_CTRL_FREEZE_BIT];
    end
  end

  logic [AW:0] levelNow;
  assign levelNow = wPtr_reg - rPtr_reg;

  always_comb begin
    prdata  = '0;
    pslverr = 1'b0;
    case (paddr)
      DCFF_CTRL_ADDR: begin
        prdata[DCFF_CTRL_FREEZE_BIT] = freeze_reg;
      end
      DCFF_STATUS_ADDR: begin
        prdata[DCFF_ST_FLAGS_LSB +: 5] = flags_reg;
        prdata[DCFF_ST_SERIAL_BIT]     = serialOk_reg;
        prdata[DCFF_ST_MODE_BIT]       = asyncMode_reg;
      end
      DCFF_LEVEL_ADDR: begin
        prdata[AW:0] = levelNow;
      end
      DCFF_OFFSET_ADDR: begin
        prdata[AW-1:0]                    = emptyOfs_reg;
        prdata[DCFF_OFS_FULL_LSB +: AW]   = fullOfs_reg;
      end
      default: begin
        pslverr = psel & penable;
      end
    endcase
  end

  assign pready = 1'b1;

  // Checks
  a_read_loads_head: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && doRead |=> dataOut_reg == $past(headWord))
    else $error("read did not load head word");

  a_idle_holds_out: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && !doRead && !resetAny |=> $stable(dataOut_reg))
    else $error("output register changed without a read");

  a_empty_blocks_read: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    clkEn && !flags_reg.emptyN && !resetAny
      |=> rPtr_reg == $past(rPtr_reg))
    else $error("read taken while empty flag low");

  a_full_blocks_write: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    clkEn && !flags_reg.fullN && !resetAny
      |=> wPtr_reg == $past(wPtr_reg))
    else $error("write taken while full flag low");

  a_full_true_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    levelNow <= DEPTH_L)
    else $error("stored level above depth");

  a_serial_shift_bit: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    clkEn && doShift && mrNS && !apbWrite |=>
      fullOfs_reg[AW-1] == $past(serInS)
      && emptyOfs_reg[AW-1] == $past(fullOfs_reg[0]))
    else $error("serial bit not shifted in");

  a_serial_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && serEnNS && mrNS && !apbWrite |=>
      $stable(emptyOfs_reg) && $stable(fullOfs_reg))
    else $error("offsets changed with serial enable high");

  a_reset_levels: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && resetAny |=> !flags_reg.emptyN && flags_reg.fullN
      && !flags_reg.almostEmptyN && flags_reg.almostFullN
      && flags_reg.halfFullN && dataOut_reg == '0
      && wPtr_reg == '0)
    else $error("reset did not restore flags and pointers");

  a_half_full_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    clkEn && doWrite && levelNew > HALF_L && !resetAny
      |=> !flags_reg.halfFullN)
    else $error("half-full not set above half depth");

  a_drive_matches_reg: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    clkEn && !doRead && !resetAny ##1 readDataOe
      |-> readDataOut == $past(dataOut_reg))
    else $error("driven data differs from output register");

endmodule

// ==== test/dcff_host.sv ====
// Purpose: Host logic on the pin side of the FIFO flag controller
// Assumes: Pin clocks made from clk_sys, 3 cycles high and 3 low
// Notes:   Released data and serial-in lines show the inverse of their last value; enables and load return high
`timescale 1ns/1ps

module dcff_host #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_sys,
  output logic                  writeClkPin,
  output logic                  readClkPin,
  output logic                  writeEnN,
  output logic                  readEnN,
  output logic                  serialEnableN,
  output logic                  offsetLoadN,
  output logic                  serialIn,
  output logic                  offsetSelect0,
  output logic                  offsetSelect1,
  output logic                  flagTimingMode,
  output logic                  masterResetN,
  output logic                  partialResetN,
  output logic      [WIDTH-1:0] writeDataIn
);
  initial begin
    {writeClkPin, readClkPin, serialIn} = 3'b000;
    {writeEnN, readEnN, masterResetN, partialResetN} = 4'b1111;
    {offsetSelect1, offsetSelect0, flagTimingMode} = 3'b001;
    serialEnableN = 1'b1;
    offsetLoadN   = 1'b1;
    writeDataIn   = '0;
  end

  // Pin clocks stand still between calls
  task automatic pulse(input logic wr);
    if (wr) writeClkPin <= 1'b1;
    else readClkPin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    {writeClkPin, readClkPin} <= 2'b00;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic wclk(input logic enN, input logic [WIDTH-1:0] d,
                      input logic ldN, input logic senN, input logic si);
    @(posedge clk_sys);
    writeEnN      <= enN;
    writeDataIn   <= d;
    offsetLoadN   <= ldN;
    serialEnableN <= senN;
    serialIn      <= si;
    pulse(1'b1);
    writeEnN      <= 1'b1;
    writeDataIn   <= ~d;
    offsetLoadN   <= 1'b1;
    serialEnableN <= 1'b1;
    serialIn      <= ~si;
  endtask

  task automatic rclk(input logic enN);
    @(posedge clk_sys);
    readEnN <= enN;
    pulse(1'b0);
    readEnN <= 1'b1;
  endtask

  task automatic mrst(input logic ldN, input logic [1:0] sel,
                      input logic mode, input logic part);
    @(posedge clk_sys);
    offsetLoadN <= ldN;
    {offsetSelect1, offsetSelect0} <= sel;
    flagTimingMode <= mode;
    serialIn <= 1'b0;
    if (part) partialResetN <= 1'b0;
    else masterResetN <= 1'b0;
    repeat (6) @(posedge clk_sys);
    {masterResetN, partialResetN} <= 2'b11;
    repeat (6) @(posedge clk_sys);
    offsetLoadN <= 1'b1;
  endtask
endmodule

// ==== test/tb_dcff_ctrl.sv ====
// Purpose: Self-checking bench for the FIFO read and flag controller
// Assumes: DEPTH cut to 16 so fill and drain stay short
// Notes:   Pin side comes from dcff_host except output enable, registers over APB
`timescale 1ns/1ps

module tb_dcff_ctrl;
  import dcff_pkg::*;

  localparam int DEPTH = 16;
  localparam logic [7:0] SER_PAT = 8'hA5;

  logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, readDataOut, writeDataIn, rDat;
  logic        writeClkPin, readClkPin, writeEnN, readEnN, outputEnN;
  logic        serialEnableN, offsetLoadN, serialIn, offsetSelect0;
  logic        offsetSelect1, flagTimingMode, masterResetN, partialResetN;
  logic        readDataOe, rErr, clkEn;
  dcff_flags_t flags;
  int          fail_count, tests_run, cyc;

  dcff_ctrl #(.DEPTH(DEPTH), .WIDTH(32)) u_dut (
    .clk_sys, .nrst, .clkEn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .writeClkPin, .readClkPin,
    .writeEnN, .readEnN, .outputEnN, .serialEnableN, .offsetLoadN,
    .serialIn, .offsetSelect0, .offsetSelect1, .flagTimingMode,
    .masterResetN, .partialResetN, .writeDataIn, .readDataOut,
    .readDataOe, .flags
  );

  dcff_host #(.WIDTH(32)) u_host (
    .clk_sys, .writeClkPin, .readClkPin, .writeEnN, .readEnN,
    .serialEnableN, .offsetLoadN, .serialIn, .offsetSelect0,
    .offsetSelect1, .flagTimingMode, .masterResetN, .partialResetN,
    .writeDataIn
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles; this only cuts a hang
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rDat = prdata;
    rErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    {nrst, psel, penable, pwrite, outputEnN, clkEn} = 6'b000011;
    paddr  = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk(flags, DCFF_FLAGS_RST);
    chk(readDataOut, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rErr, 1'b1);
    chk(rDat, 32'h0000_0000);
    // Default pair from straps, synchronous flags
    u_host.mrst(1'b0, 2'b00, 1'b1, 1'b0);
    apb(1'b0, DCFF_OFFSET_ADDR, 32'h0000_0000);
    chk(rDat, 32'h0007_0007);
    apb(1'b0, DCFF_STATUS_ADDR, 32'h0000_0000);
    chk(rDat[6:0], {2'b00, DCFF_FLAGS_RST});
    apb(1'b1, DCFF_OFFSET_ADDR, 32'h0002_0003);
    u_host.wclk(1'b0, 32'hA5A5_0001, 1'b1, 1'b1, 1'b0);
    chk(readDataOut, 32'h0000_0000);
    u_host.rclk(1'b1);
    chk(flags.emptyN, 1'b0);
    chk(readDataOut, 32'h0000_0000);
    u_host.rclk(1'b1);
    chk(flags.emptyN, 1'b1);
    u_host.rclk(1'b0);
    chk(readDataOut, 32'hA5A5_0001);
    u_host.rclk(1'b1);
    chk(flags.emptyN, 1'b0);
    u_host.rclk(1'b0);
    chk(readDataOut, 32'hA5A5_0001);
    outputEnN <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(readDataOe, 1'b1);
    outputEnN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(readDataOe, 1'b0);
    // Fill past full, offsets empty 3 full 2 kept over partial reset
    u_host.mrst(1'b1, 2'b00, 1'b1, 1'b1);
    chk(flags, DCFF_FLAGS_RST);
    for (int i = 1; i <= DEPTH + 1; i++) begin
      u_host.wclk(1'b0, 32'hC0DE_0000 + i, 1'b1, 1'b1, 1'b0);
      apb(1'b0, DCFF_LEVEL_ADDR, 32'h0000_0000);
      chk(rDat, (i > DEPTH) ? DEPTH : i);
      chk(flags.fullN, i < DEPTH);
      chk(flags.halfFullN, i <= DEPTH / 2);
      chk(flags.almostFullN, i < DEPTH - 2);
      chk(flags.almostEmptyN, 1'b0);
    end
    // First read edge only refreshes the read side's pointer copy
    u_host.rclk(1'b1);
    chk(flags.almostEmptyN, 1'b0);
    u_host.rclk(1'b1);
    chk(flags.almostEmptyN, 1'b1);
    for (int i = 1; i <= DEPTH; i++) begin
      u_host.rclk(1'b0);
      chk(readDataOut, 32'hC0DE_0000 + i);
      chk(flags.halfFullN, DEPTH - i <= DEPTH / 2);
      chk(flags.almostEmptyN, DEPTH - i > 3);
      if (i == 1) begin
        chk(flags.fullN, 1'b0);
        u_host.wclk(1'b1, 32'h0000_0000, 1'b1, 1'b1, 1'b0);
        chk(flags.fullN, 1'b0);
        u_host.wclk(1'b1, 32'h0000_0000, 1'b1, 1'b1, 1'b0);
        chk(flags.fullN, 1'b1);
      end
    end
    // Asynchronous flag timing, offsets 7 and 7
    u_host.mrst(1'b0, 2'b00, 1'b0, 1'b0);
    apb(1'b0, DCFF_STATUS_ADDR, 32'h0000_0000);
    chk(rDat[6], 1'b1);
    for (int i = 1; i <= 9; i++) begin
      u_host.wclk(1'b0, 32'h5000_0000 + i, 1'b1, 1'b1, 1'b0);
      chk(flags.almostEmptyN, i > 7);
      chk(flags.almostFullN, i < 9);
    end
    u_host.rclk(1'b1);
    u_host.rclk(1'b1);
    chk(flags.emptyN, 1'b1);
    chk(flags.almostFullN, 1'b0);
    u_host.rclk(1'b0);
    chk(flags.almostFullN, 1'b1);
    chk(readDataOut, 32'h5000_0001);
    u_host.rclk(1'b0);
    chk(flags.almostEmptyN, 1'b0);
    chk(readDataOut, 32'h5000_0002);
    // Freeze bit refuses reads; clock enable low stalls the pin side
    apb(1'b1, DCFF_CTRL_ADDR, 32'h0000_0001);
    apb(1'b0, DCFF_CTRL_ADDR, 32'h0000_0000);
    chk(rDat, 32'h0000_0001);
    u_host.rclk(1'b0);
    chk(readDataOut, 32'h5000_0002);
    apb(1'b1, DCFF_CTRL_ADDR, 32'h0000_0000);
    clkEn <= 1'b0;
    u_host.wclk(1'b0, 32'h0BAD_0000, 1'b1, 1'b1, 1'b0);
    clkEn <= 1'b1;
    apb(1'b0, DCFF_LEVEL_ADDR, 32'h0000_0000);
    chk(rDat, 32'h0000_0007);
    // Serial offsets: empty 5 then full A, one bit per write edge
    u_host.mrst(1'b1, 2'b00, 1'b1, 1'b0);
    apb(1'b0, DCFF_STATUS_ADDR, 32'h0000_0000);
    chk(rDat[5], 1'b1);
    for (int b = 0; b < 8; b++) begin
      u_host.wclk(1'b1, 32'h0000_0000, 1'b0, 1'b0, SER_PAT[b]);
    end
    u_host.wclk(1'b1, 32'h0000_0000, 1'b0, 1'b1, 1'b1);
    apb(1'b0, DCFF_OFFSET_ADDR, 32'h0000_0000);
    chk(rDat, 32'h000A_0005);
    end_sim();
  end
endmodule
